// [inc/host_port_pkg.sv]
// constants for the host word port: widths, access timing, ready modes
// assumes a single 100 MHz ref_clk domain inside the device
package host_port_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int CODE_ADDR_W = 12;
  localparam int CLK_PERIOD_PS = 10000;
  // controller cycle and access windows, in picoseconds
  localparam int TC_PS = 25000;
  localparam int WR_MIN_PS = 25000;
  localparam int WR_MAX_PS = 100000;
  localparam int RD_MIN_PS = 37500;
  localparam int RD_MAX_PS = 200000;
  // least times round up, longest round down
  localparam int WR_MIN_CYC = (WR_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_MAX_CYC = WR_MAX_PS / CLK_PERIOD_PS;
  localparam int RD_MIN_CYC = (RD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RD_MAX_CYC = RD_MAX_PS / CLK_PERIOD_PS;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WR_WAIT = CNT_W'(WR_MIN_CYC);
  localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(RD_MIN_CYC);
  // active high drive time of ready before release, per select code
  localparam int HI_SEL_W = 2;
  localparam logic [2:0] HI_CYC_0 = 3'h0;
  localparam logic [2:0] HI_CYC_1 = 3'h1;
  localparam logic [2:0] HI_CYC_2 = 3'h2;
  localparam logic [2:0] HI_CYC_3 = 3'h3;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_READY = 3'b011,
    ST_DONE = 3'b010,
    ST_HIGH = 3'b110
  } port_state_e;
endpackage

// [rtl/pin_sync.sv]
// two flip-flop synchroniser for a bus of asynchronous pins
// assumes the pins are quasi-static across the sampling edges
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// [rtl/host_dpram_access_port.sv]
// asynchronous 16-bit host port onto the shared message RAM and code memory
// assumes the RAM and code memory answer on the cycle after a read strobe
`timescale 1ns/1ps
// What this block does
// - lowest address pin picks even or odd word
// - interrupt/time pin only pulled low, otherwise released
// - interrupt/time pin signals programmed and protocol events
// - ready pulled low, optionally driven high briefly before release
// - clock enable low gives asynchronous ready; host synchronises it
// - clock enable high aligns ready to host bus clock
// - host accesses accepted without relation to the microtick clock
// - shared message RAM reachable for host reads and writes
// - host reaches instruction code memory for load, test, verify
// - 12-bit word address, 16-bit tristate data bus, bit 0 lsb
// - select, strobe, enable inputs and ready, interrupt outputs active low
// - status indicator port shows configured protocol states and events
// - write ready between 1 and 4 controller cycles after strobe
// - read ready between 1.5 and 8 controller cycles after strobe
// - clock-aligned ready lasts exactly one host clock cycle
module host_dpram_access_port
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic ready_n_out,
  output logic ready_n_oe,
  output logic interrupt_time_n_out,
  output logic interrupt_time_n_oe,
  input wire logic host_bus_clock,
  input wire logic host_clock_enable,
  input wire logic [HI_SEL_W-1:0] ready_high_sel,
  input wire logic code_space_sel,
  output logic ram_wr,
  output logic ram_rd,
  output logic [ADDR_W-1:0] ram_addr,
  output logic [DATA_W-1:0] ram_wdata,
  input wire logic [DATA_W-1:0] ram_rdata,
  output logic code_wr,
  output logic code_rd,
  output logic [CODE_ADDR_W-1:0] code_addr,
  output logic [DATA_W-1:0] code_wdata,
  input wire logic [DATA_W-1:0] code_rdata,
  input wire logic event_pulse,
  input wire logic [2:0] indicator_in,
  output logic [2:0] status_indicator_port
);
  localparam int SYNC_W = 3 + ADDR_W + DATA_W + 2;

  logic [SYNC_W-1:0] pins_s;
  logic cs_n_s, we_n_s, oe_n_s, hclk_s, hclk_d_r;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] din_s;
  port_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic is_wr_r;
  logic [2:0] hi_cnt_r;
  logic [2:0] hi_len;
  logic irq_r;

  // select, strobe, enable, address and data pins, host clock and clock enable pass two flip-flops
  pin_sync #(.W(SYNC_W), .RST_VAL({3'h7, {(SYNC_W-3){1'b0}}})) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({chip_select_n, write_strobe_n, output_enable_n, addr, data_in,
               host_bus_clock, host_clock_enable}),
    .sync_out(pins_s)
  );
  logic hce_s;
  assign {cs_n_s, we_n_s, oe_n_s, addr_s, din_s, hclk_s, hce_s} = pins_s;

  wire wr_req = !cs_n_s && !we_n_s;
  wire rd_req = !cs_n_s && !oe_n_s && we_n_s;
  wire access_on = wr_req || rd_req;
  wire hclk_rise = hclk_s && !hclk_d_r;
  // ready goes out at once, or on the next host clock rise
  wire ready_slot = !hce_s || hclk_rise;
  wire min_met = (cnt_r >= (is_wr_r ? WR_WAIT : RD_WAIT));
  // address lsb is the word select; whole address is a word index
  wire to_code = code_space_sel;
  wire start = (state_r == ST_IDLE) && access_on;

  assign hi_len = (ready_high_sel == 2'h0) ? HI_CYC_0 :
                  (ready_high_sel == 2'h1) ? HI_CYC_1 :
                  (ready_high_sel == 2'h2) ? HI_CYC_2 : HI_CYC_3;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (access_on) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!access_on) begin
          state_nxt = ST_IDLE;
        end else if (min_met && ready_slot) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        // one host clock cycle in aligned mode
        if (!access_on) begin
          state_nxt = (hi_len != 3'h0) ? ST_HIGH : ST_IDLE;
        end else if (hce_s && hclk_rise) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!access_on) begin
          state_nxt = (hi_len != 3'h0) ? ST_HIGH : ST_IDLE;
        end
      end
      ST_HIGH: begin
        if (hi_cnt_r == 3'h1 || hi_cnt_r == 3'h0) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      is_wr_r <= 1'b0;
      hclk_d_r <= 1'b0;
      hi_cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      hclk_d_r <= hclk_s;
      cnt_r <= start ? CNT_W'(2) : ((cnt_r != '1) ? cnt_r + CNT_W'(1) : cnt_r);
      if (start) begin
        is_wr_r <= wr_req;
      end
      hi_cnt_r <= (state_nxt == ST_HIGH && state_r != ST_HIGH) ? hi_len :
                  ((hi_cnt_r != 3'h0) ? hi_cnt_r - 3'h1 : 3'h0);
    end
  end

  // memory strobes, one cycle each at access start
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
      code_wr <= 1'b0;
      code_rd <= 1'b0;
      ram_addr <= '0;
      code_addr <= '0;
      ram_wdata <= DATA_RST;
      code_wdata <= DATA_RST;
    end else begin
      ram_wr <= start && wr_req && !to_code;
      ram_rd <= start && rd_req && !to_code;
      code_wr <= start && wr_req && to_code;
      code_rd <= start && rd_req && to_code;
      ram_addr <= addr_s;
      code_addr <= addr_s;
      ram_wdata <= din_s;
      code_wdata <= din_s;
    end
  end

  // read data captured the cycle after the read strobe, held for the access
  logic rd_cap_r, rd_code_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_cap_r <= 1'b0;
      rd_code_r <= 1'b0;
      data_out <= DATA_RST;
      data_oe <= 1'b0;
    end else begin
      rd_cap_r <= ram_rd || code_rd;
      rd_code_r <= code_rd;
      if (rd_cap_r) begin
        data_out <= rd_code_r ? code_rdata : ram_rdata;
      end
      data_oe <= rd_req && (state_r != ST_IDLE);
    end
  end

  // ready: low while ready, high for the selected time, else released
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ready_n_out <= 1'b1;
      ready_n_oe <= 1'b0;
    end else begin
      ready_n_out <= !(state_nxt == ST_READY || state_nxt == ST_DONE);
      ready_n_oe <= (state_nxt == ST_READY) || (state_nxt == ST_HIGH) ||
                    (state_nxt == ST_DONE && !hce_s);
    end
  end

  // interrupt/time: event pulse pulls low for one cycle, never driven high
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
      status_indicator_port <= 3'h0;
    end else begin
      irq_r <= event_pulse;
      status_indicator_port <= indicator_in;
    end
  end
  assign interrupt_time_n_out = 1'b0;
  assign interrupt_time_n_oe = irq_r;
endmodule

// [tb/host_port_asserts.sv]
// timing and routing checks on the host word port, bound to its pins
// assumes one ref_clk domain with synchronous active-high sys_rst
`timescale 1ns/1ps
module host_port_asserts
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic data_oe,
  input wire logic ready_n_out,
  input wire logic ready_n_oe,
  input wire logic interrupt_time_n_out,
  input wire logic interrupt_time_n_oe,
  input wire logic host_clock_enable,
  input wire logic [HI_SEL_W-1:0] ready_high_sel,
  input wire logic code_space_sel,
  input wire logic ram_wr,
  input wire logic ram_rd
);
  wire rlow = ready_n_oe & ~ready_n_out;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_intr_only_low: assert property (
    interrupt_time_n_oe |-> !interrupt_time_n_out) else $error("intr driven high");
  a_intr_one_cycle: assert property (
    interrupt_time_n_oe |=> !interrupt_time_n_oe) else $error("intr held");
  a_read_drive_only: assert property (
    $rose(data_oe) |-> write_strobe_n && !output_enable_n && !chip_select_n)
    else $error("bus driven outside read");
  a_ram_route: assert property (
    ram_wr || ram_rd |-> !code_space_sel) else $error("ram hit in code space");
  a_write_window: assert property (
    $fell(write_strobe_n) && !chip_select_n && !host_clock_enable
    |-> !rlow [*3] ##[1:8] rlow) else $error("write ready out of window");
  a_read_window: assert property (
    $fell(output_enable_n) && !chip_select_n && !host_clock_enable
    |-> !rlow [*4] ##[1:17] rlow) else $error("read ready out of window");
  a_async_release: assert property (
    $rose(chip_select_n) && !host_clock_enable |-> ##[1:5] !rlow)
    else $error("ready not ended");
  a_no_high_drive: assert property (
    $fell(rlow) && ready_high_sel == 2'h0 |-> !ready_n_oe) else $error("ready driven high");
endmodule
bind host_dpram_access_port host_port_asserts chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n),
  .output_enable_n(output_enable_n),
  .data_oe(data_oe),
  .ready_n_out(ready_n_out),
  .ready_n_oe(ready_n_oe),
  .interrupt_time_n_out(interrupt_time_n_out),
  .interrupt_time_n_oe(interrupt_time_n_oe),
  .host_clock_enable(host_clock_enable),
  .ready_high_sel(ready_high_sel),
  .code_space_sel(code_space_sel),
  .ram_wr(ram_wr),
  .ram_rd(ram_rd)
);

// [tb/host_mem_model.sv]
// synchronous stand-in for the message RAM and code memory
// assumes one-cycle strobes; read data holds until the next read
`timescale 1ns/1ps
module host_mem_model
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic ram_wr,
  input wire logic ram_rd,
  input wire logic [ADDR_W-1:0] ram_addr,
  input wire logic [DATA_W-1:0] ram_wdata,
  output logic [DATA_W-1:0] ram_rdata,
  input wire logic code_wr,
  input wire logic code_rd,
  input wire logic [CODE_ADDR_W-1:0] code_addr,
  input wire logic [DATA_W-1:0] code_wdata,
  output logic [DATA_W-1:0] code_rdata
);
  logic [DATA_W-1:0] ram [1<<ADDR_W];
  logic [DATA_W-1:0] code [1<<CODE_ADDR_W];
  always_ff @(posedge ref_clk) begin
    if (ram_wr) ram[ram_addr] <= ram_wdata;
    if (ram_rd) ram_rdata <= ram[ram_addr];
    if (code_wr) code[code_addr] <= code_wdata;
    if (code_rd) code_rdata <= code[code_addr];
  end
endmodule

// [tb/host_dpram_access_port_tb_top.sv]
// word accesses through the host port against a memory model
// assumes inputs change 1 ns after ref_clk rises
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module host_dpram_access_port_tb_top;
  import host_port_pkg::*;
  logic ref_clk = 0, sys_rst = 1, chip_select_n = 1, write_strobe_n = 1, output_enable_n = 1;
  logic host_bus_clock = 0, host_clock_enable = 0, code_space_sel = 0, event_pulse = 0;
  logic [ADDR_W-1:0] addr = '0, ram_addr;
  logic [CODE_ADDR_W-1:0] code_addr;
  logic [DATA_W-1:0] data_in = '0, data_out, ram_rdata, code_rdata, ram_wdata, code_wdata;
  logic [HI_SEL_W-1:0] ready_high_sel = '0;
  logic [2:0] indicator_in = '0, status_indicator_port;
  logic data_oe, ready_n_out, ready_n_oe, interrupt_time_n_out, interrupt_time_n_oe;
  logic ram_wr, ram_rd, code_wr, code_rd;
  int failures = 0, compares = 0, hi_cnt, lo_cnt, n;
  // pin level with the weak pull-up
  wire rdy_pin = ready_n_oe ? ready_n_out : 1'b1;
  always #5 ref_clk = ~ref_clk;
  // host clock period in ref_clk cycles; its edges fall on ref_clk falling edges, never on a rising one
  localparam int HCLK_CYC = 6;
  always #(HCLK_CYC * 5) host_bus_clock = ~host_bus_clock;
  host_dpram_access_port dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n),
    .addr(addr),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .ready_n_out(ready_n_out),
    .ready_n_oe(ready_n_oe),
    .interrupt_time_n_out(interrupt_time_n_out),
    .interrupt_time_n_oe(interrupt_time_n_oe),
    .host_bus_clock(host_bus_clock),
    .host_clock_enable(host_clock_enable),
    .ready_high_sel(ready_high_sel),
    .code_space_sel(code_space_sel),
    .ram_wr(ram_wr),
    .ram_rd(ram_rd),
    .ram_addr(ram_addr),
    .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata),
    .code_wr(code_wr),
    .code_rd(code_rd),
    .code_addr(code_addr),
    .code_wdata(code_wdata),
    .code_rdata(code_rdata),
    .event_pulse(event_pulse),
    .indicator_in(indicator_in),
    .status_indicator_port(status_indicator_port)
  );
  host_mem_model mem (
    .ref_clk(ref_clk),
    .ram_wr(ram_wr),
    .ram_rd(ram_rd),
    .ram_addr(ram_addr),
    .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata),
    .code_wr(code_wr),
    .code_rd(code_rd),
    .code_addr(code_addr),
    .code_wdata(code_wdata),
    .code_rdata(code_rdata)
  );
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr = a;
    data_in = wr ? d : ~d; // whole word on every access
    chip_select_n = 0;
    write_strobe_n = !wr;
    output_enable_n = wr;
    n = 0;
    while (rdy_pin !== 1'b0 && n < 40) begin tick(1); n++; end
    if (rdy_pin !== 1'b0) begin failures++; tally_and_finish(); end
    `CHK(data_oe, !wr)
    if (!wr) `CHK(data_out, d)
    lo_cnt = 0;
    while (host_clock_enable && rdy_pin === 1'b0 && lo_cnt < 40) begin tick(1); lo_cnt++; end
    if (host_clock_enable) `CHK(lo_cnt, HCLK_CYC)
    chip_select_n = 1;
    write_strobe_n = 1;
    output_enable_n = 1;
    hi_cnt = 0;
    repeat (12) begin tick(1); if (ready_n_oe === 1'b1 && ready_n_out === 1'b1) hi_cnt++; end
    if (!host_clock_enable) `CHK(hi_cnt, int'(ready_high_sel))
    `CHK(rdy_pin, 1'b1)
  endtask
  initial begin
    tick(20);
    `CHK(ready_n_oe, 1'b0)
    sys_rst = 0;
    tick(3);
    access(1, 12'h000, 16'hA5C3);
    access(1, 12'h001, 16'h5A3C);
    access(1, 12'hFFF, 16'hFFFF);
    access(0, 12'h000, 16'hA5C3);
    access(0, 12'h001, 16'h5A3C);
    access(0, 12'hFFF, 16'hFFFF);
    code_space_sel = 1;
    access(1, 12'h001, 16'h1234);
    access(0, 12'h001, 16'h1234);
    code_space_sel = 0;
    access(0, 12'h001, 16'h5A3C);
    // even codes write the word, odd codes read it back
    for (int s = 0; s < 4; s++) begin
      ready_high_sel = s[1:0];
      access(!s[0], 12'h010, 16'h00F0);
    end
    // aligned mode is for non-critical hosts only
    host_clock_enable = 1;
    tick(4);
    access(1, 12'h020, 16'hC0DE);
    access(0, 12'h020, 16'hC0DE);
    event_pulse = 1;
    n = 0;
    repeat (8) begin
      tick(1);
      event_pulse = 0;
      if (interrupt_time_n_oe === 1'b1 && interrupt_time_n_out === 1'b0) n++;
    end
    `CHK(n, 1)
    indicator_in = 3'h5;
    tick(4);
    `CHK(status_indicator_port, 3'h5)
    tally_and_finish();
  end
endmodule
